// >>> nhc_dev_model.sv
// Behavioural NAND device facing the host controller
`timescale 1ns/100ps
module nhc_dev_model
    import nhc_pkg::*;
#(
    parameter int BUSY = 20,
    parameter logic [7:0] MAKER = 8'h5A, // Arbitrary value
    parameter logic [7:0] DEVICE = 8'hC3 // Arbitrary value
) (
    input wire logic aclk, ce_n, cle, we_n, re_n, wp_n,
    input wire logic [7:0] io_host,
    output logic [7:0] io_dev,
    output logic rb
);
    logic [7:0] cmd = 8'h00, q;
    logic we_q = 1'b1, re_q = 1'b1;
    int cnt = 0, idx = 0;
    // one chip, two levels, 2 KB pages
    wire [39:0] ids = {MAKER, DEVICE, 8'h80, 8'h15, 8'h72};
    assign q = (cmd == CMD_STATUS) ? {wp_n, rb, rb, 5'h00} : ids[8*(4-idx%5) +: 8];
    // Released bus shows the inverse so a stale byte cannot pass
    assign io_dev = (!re_n && !ce_n) ? q : ~q;
    // busy until transfer or program is over
    assign rb = (cnt == 0);
    // commands latch on the rising write strobe
    always @(posedge aclk) begin
        we_q <= we_n;
        re_q <= re_n;
        if (cnt > 0) cnt <= cnt - 1;
        if (re_n && !re_q) idx <= idx + 1;
        if (we_n && !we_q && cle && !ce_n) begin
            cmd <= io_host;
            idx <= 0;
            if (io_host inside {CMD_PROG, CMD_CACHE_PROG, CMD_ERASE_GO, CMD_COPY_READ}) cnt <= BUSY;
        end
    end
endmodule : nhc_dev_model

// >>> nhc_host.sv
// NAND host controller: AXI4-Lite register slave driving the NAND pins
// What this block does
// - Cache programming starts with 15h after data; device busy during cache transfer.
// - Restart cached programming when target block address changes; the block refuses a changed block address instead.
// - Cached programming ends with 10h; ready means last page programmed.
// - Current result valid only with page-buffer ready, previous with cache ready.
// - Page copy gives target address after 8Ch; data input optional.
// - Page copy ends with 8Ch then 10h, or is cut short by FFh.
// - Write protect stays high from 3Ah until 10h is latched; it falls while the copy program is still busy.
// - Erase is 60h, block address, D0h; starts on D0h strobe.
// - After 70h the status byte is read with read strobes.
// - Trust pass/fail only when ready after a program or erase.
// - Page copy begins with 00h, address, 3Ah.
// - Intermediate copy targets use 8Ch, address, data, 15h.
// - After 80h only 85h, 10h, 15h or FFh may follow.
// - While busy only 70h or FFh may be issued.
`timescale 1ns/100ps
module nhc_host
    import nhc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic nand_ce_n,
    output logic nand_cle,
    output logic nand_ale,
    output logic nand_we_n,
    output logic read_strobe_n,
    output logic nand_wp_n,
    output logic [7:0] nand_io_out,
    output logic nand_io_oe,
    input wire logic [7:0] nand_io_in,
    input wire logic ready_busy_out
);
    typedef enum logic [2:0] {ST_IDLE, ST_STROBE, ST_RECOVER, ST_READ_LOW, ST_WAIT} nhc_state_e;

    // Bus group state
    logic bvalid_ff, nxt_bvalid;
    logic [1:0] bresp_ff, nxt_bresp;
    logic rvalid_ff, nxt_rvalid;
    logic [1:0] rresp_ff, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [1:0] ctrl_ff, nxt_ctrl;
    logic err_ff, nxt_err;
    // Engine group state
    nhc_state_e state_ff, nxt_state;
    nhc_kind_e kind_ff, nxt_kind;
    logic [7:0] byte_ff, nxt_byte;
    logic cle_ff, nxt_cle, ale_ff, nxt_ale, we_n_ff, nxt_we_n, re_n_ff, nxt_re_n;
    logic oe_ff, nxt_oe, wp_n_ff, nxt_wp_n;
    logic [2:0] wb_cnt_ff, nxt_wb_cnt;
    logic serial_ff, nxt_serial, cache_ff, nxt_cache, copy_ff, nxt_copy;
    logic [9:0] blk_ff, nxt_blk;
    logic [2:0] addr_idx_ff, nxt_addr_idx;
    logic after_stat_ff, nxt_after_stat, after_id_ff, nxt_after_id;
    logic [2:0] id_idx_ff, nxt_id_idx;
    logic [7:0] id_ff [5], nxt_id [5];
    logic [7:0] last_ff, nxt_last, nstat_ff, nxt_nstat;
    logic prog_ctx_ff, nxt_prog_ctx, cache_ctx_ff, nxt_cache_ctx;
    // Shared combinational terms
    logic wr_go, rd_go, cyc_req, cyc_legal, cyc_go, dev_busy;
    nhc_kind_e req_kind;
    logic [7:0] req_byte;
    logic cur_valid, prev_valid;

    function automatic logic [31:0] nhc_word(input logic [7:0] b);
        nhc_word = {24'h0, b};
    endfunction : nhc_word

    // Handshakes: write address and data are taken together
    assign wr_go = awvalid && wvalid && !bvalid_ff;
    assign awready = wr_go;
    assign wready = wr_go;
    assign arready = !rvalid_ff;
    assign rd_go = arvalid && !rvalid_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign rvalid = rvalid_ff;
    assign rresp = rresp_ff;
    assign rdata = rdata_ff;
    assign nand_ce_n = !ctrl_ff[CTRL_CE];
    assign nand_cle = cle_ff;
    assign nand_ale = ale_ff;
    assign nand_we_n = we_n_ff;
    assign read_strobe_n = re_n_ff;
    assign nand_wp_n = wp_n_ff;
    assign nand_io_out = byte_ff;
    assign nand_io_oe = oe_ff;

    assign req_kind = nhc_kind_e'(wdata[CYC_KIND_LSB +: KIND_W]);
    assign req_byte = wdata[7:0];
    assign cyc_req = wr_go && (awaddr == ADDR_CYCLE) && (wstrb[1:0] == 2'h3);
    // Busy from the pin, or the short window before the pin falls
    assign dev_busy = !ready_busy_out || (wb_cnt_ff != 3'h0);

    // pass/fail validity gated by readiness flags
    assign cur_valid = prog_ctx_ff && nstat_ff[SB_PB_READY];
    assign prev_valid = cache_ctx_ff && nstat_ff[SB_DC_READY];

    // Legality of a requested pin cycle
    always_comb begin
        cyc_legal = 1'b1;
        unique case (req_kind)
            KIND_CMD: begin
                // only status or reset while busy
                if (dev_busy && (req_byte != CMD_STATUS) && (req_byte != CMD_RESET)) begin
                    cyc_legal = 1'b0;
                end
                if (serial_ff && (req_byte != CMD_COL_CHG) && (req_byte != CMD_PROG)
                    && (req_byte != CMD_CACHE_PROG) && (req_byte != CMD_RESET)) begin
                    cyc_legal = 1'b0;
                end
                // program confirms need a serial input first
                if (!serial_ff && ((req_byte == CMD_PROG) || (req_byte == CMD_CACHE_PROG))) begin
                    cyc_legal = 1'b0;
                end
                if (copy_ff && (req_byte == CMD_SERIAL_IN)) begin
                    cyc_legal = 1'b0;
                end
            end
            KIND_ADDR: begin
                // block change inside a cached or copy run is refused
                if ((cache_ff || copy_ff) && serial_ff) begin
                    if ((addr_idx_ff == ADDR_IDX_BLK_LO) && (req_byte[7:BLK_LSB] != blk_ff[1:0])) begin
                        cyc_legal = 1'b0;
                    end
                    if ((addr_idx_ff == ADDR_IDX_BLK_HI) && (req_byte != blk_ff[9:2])) begin
                        cyc_legal = 1'b0;
                    end
                end
            end
            // data input only inside a program sequence
            KIND_WDATA: cyc_legal = serial_ff;
            default: cyc_legal = 1'b1;
        endcase
    end
    assign cyc_go = cyc_req && (state_ff == ST_IDLE) && cyc_legal;

    // Bus group next values
    always_comb begin
        nxt_bvalid = bvalid_ff && !bready;
        nxt_bresp = bresp_ff;
        nxt_rvalid = rvalid_ff && !rready;
        nxt_rresp = rresp_ff;
        nxt_rdata = rdata_ff;
        nxt_ctrl = ctrl_ff;
        nxt_err = err_ff;
        if (wr_go) begin
            nxt_bvalid = 1'b1;
            nxt_bresp = RESP_OKAY;
            if ((awaddr == ADDR_CTRL) && wstrb[0]) begin
                nxt_ctrl = {wdata[CTRL_CE], wdata[CTRL_WP_EN]};
                if (wdata[CTRL_ERR_CLR]) begin
                    nxt_err = 1'b0;
                end
            end else if (!cyc_go) begin
                nxt_bresp = RESP_SLVERR;
            end
        end
        // Refusal wins over a clear in the same cycle
        if (cyc_req && !cyc_go) begin
            nxt_err = 1'b1;
        end
        if (rd_go) begin
            nxt_rvalid = 1'b1;
            nxt_rresp = RESP_OKAY;
            unique case (araddr)
                ADDR_CTRL: nxt_rdata = {30'h0, ctrl_ff};
                ADDR_CYCLE: nxt_rdata = {21'h0, kind_ff, byte_ff};
                ADDR_STAT: nxt_rdata = {26'h0, copy_ff, cache_ff, serial_ff, err_ff,
                    ready_busy_out, state_ff != ST_IDLE};
                ADDR_RDATA: nxt_rdata = nhc_word(last_ff);
                ADDR_NSTAT: nxt_rdata = {20'h0, prev_valid, cur_valid,
                    nstat_ff[SB_FAIL_PREV] && prev_valid, nstat_ff[SB_FAIL_CUR] && cur_valid,
                    nstat_ff};
                ADDR_ID_LO: nxt_rdata = {id_ff[3], id_ff[2], id_ff[1], id_ff[0]};
                ADDR_ID_HI: nxt_rdata = nhc_word(id_ff[4]);
                default: begin
                    nxt_rdata = 32'h0;
                    nxt_rresp = RESP_SLVERR;
                end
            endcase
        end
    end

    // Bus group registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            rvalid_ff <= 1'b0;
            rresp_ff <= RESP_OKAY;
            rdata_ff <= 32'h0;
            ctrl_ff <= CTRL_RESET;
            err_ff <= 1'b0;
        end else begin
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rresp_ff <= nxt_rresp;
            rdata_ff <= nxt_rdata;
            ctrl_ff <= nxt_ctrl;
            err_ff <= nxt_err;
        end
    end

    // Engine next values: one pin cycle per accepted request other than a wait
    always_comb begin
        nxt_state = state_ff;
        nxt_kind = kind_ff;
        nxt_byte = byte_ff;
        nxt_cle = cle_ff;
        nxt_ale = ale_ff;
        nxt_we_n = we_n_ff;
        nxt_re_n = re_n_ff;
        nxt_oe = oe_ff;
        nxt_wb_cnt = (wb_cnt_ff != 3'h0) ? wb_cnt_ff - 3'h1 : wb_cnt_ff;
        nxt_serial = serial_ff;
        nxt_cache = cache_ff;
        nxt_copy = copy_ff;
        nxt_blk = blk_ff;
        nxt_addr_idx = addr_idx_ff;
        nxt_after_stat = after_stat_ff;
        nxt_after_id = after_id_ff;
        nxt_id_idx = id_idx_ff;
        nxt_id = id_ff;
        nxt_last = last_ff;
        nxt_nstat = nstat_ff;
        nxt_prog_ctx = prog_ctx_ff;
        nxt_cache_ctx = cache_ctx_ff;
        nxt_wp_n = ctrl_ff[CTRL_WP_EN] || copy_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (cyc_go) begin
                    nxt_kind = req_kind;
                    nxt_byte = req_byte;
                    unique case (req_kind)
                        KIND_CMD, KIND_ADDR, KIND_WDATA: begin
                            nxt_state = ST_STROBE;
                            nxt_cle = (req_kind == KIND_CMD);
                            nxt_ale = (req_kind == KIND_ADDR);
                            nxt_we_n = 1'b0;
                            nxt_oe = 1'b1;
                        end
                        KIND_RDATA: begin
                            nxt_state = ST_READ_LOW;
                            nxt_re_n = 1'b0;
                        end
                        default: nxt_state = ST_WAIT;
                    endcase
                end
            end
            ST_STROBE: begin
                // Device latches on this rising write strobe
                nxt_we_n = 1'b1;
                nxt_state = ST_RECOVER;
                if (kind_ff == KIND_CMD) begin
                    nxt_addr_idx = 3'h0;
                    nxt_after_stat = 1'b0;
                    nxt_after_id = 1'b0;
                    // busy window armed on busy-starting commands
                    if (nhc_busy_cmd(byte_ff)) begin
                        nxt_wb_cnt = WB_CNT;
                    end
                    unique case (byte_ff)
                        // serial input opens, 8Ch for copy targets
                        CMD_SERIAL_IN, CMD_COPY_PROG: nxt_serial = 1'b1;
                        // final page closes cached and copy runs
                        CMD_PROG: begin
                            nxt_serial = 1'b0;
                            nxt_cache = 1'b0;
                            nxt_copy = 1'b0;
                            nxt_prog_ctx = 1'b1;
                            nxt_cache_ctx = 1'b0;
                        end
                        CMD_CACHE_PROG: begin
                            nxt_serial = 1'b0;
                            nxt_cache = !copy_ff;
                            nxt_prog_ctx = 1'b1;
                            nxt_cache_ctx = 1'b1;
                        end
                        // erase result lands in status byte
                        CMD_ERASE_GO: begin
                            nxt_prog_ctx = 1'b1;
                            nxt_cache_ctx = 1'b0;
                        end
                        // source page read starts the copy
                        CMD_COPY_READ: begin
                            nxt_copy = 1'b1;
                            nxt_prog_ctx = 1'b0;
                        end
                        CMD_READ_GO, CMD_CREAD, CMD_CREAD_LAST: nxt_prog_ctx = 1'b0;
                        CMD_RESET: begin
                            nxt_serial = 1'b0;
                            nxt_cache = 1'b0;
                            nxt_copy = 1'b0;
                        end
                        // following reads return the status byte
                        CMD_STATUS: nxt_after_stat = 1'b1;
                        CMD_ID: begin
                            nxt_after_id = 1'b1;
                            nxt_id_idx = 3'h0;
                        end
                        default: nxt_serial = serial_ff;
                    endcase
                end else if (kind_ff == KIND_ADDR) begin
                    // block captured while no run holds it
                    if (!(cache_ff || copy_ff)) begin
                        if (addr_idx_ff == ADDR_IDX_BLK_LO) begin
                            nxt_blk[1:0] = byte_ff[7:BLK_LSB];
                        end
                        if (addr_idx_ff == ADDR_IDX_BLK_HI) begin
                            nxt_blk[9:2] = byte_ff;
                        end
                    end
                    if (addr_idx_ff != 3'h7) begin
                        nxt_addr_idx = addr_idx_ff + 3'h1;
                    end
                end
            end
            ST_READ_LOW: begin
                // Sample at the end of the low phase
                nxt_re_n = 1'b1;
                nxt_state = ST_RECOVER;
                nxt_last = nand_io_in;
                if (after_stat_ff) begin
                    nxt_nstat = nand_io_in;
                end
                if (after_id_ff && (id_idx_ff < ID_BYTES)) begin
                    nxt_id[id_idx_ff] = nand_io_in;
                    nxt_id_idx = id_idx_ff + 3'h1;
                end
            end
            ST_RECOVER: begin
                nxt_cle = 1'b0;
                nxt_ale = 1'b0;
                nxt_oe = 1'b0;
                nxt_state = ST_IDLE;
            end
            ST_WAIT: begin
                // Waits out the busy window, then for the pin to rise
                if (!dev_busy) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    // Engine registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= ST_IDLE;
            kind_ff <= KIND_CMD;
            byte_ff <= 8'h00;
            cle_ff <= 1'b0;
            ale_ff <= 1'b0;
            we_n_ff <= 1'b1;
            re_n_ff <= 1'b1;
            oe_ff <= 1'b0;
            wp_n_ff <= 1'b0;
            wb_cnt_ff <= 3'h0;
            serial_ff <= 1'b0;
            cache_ff <= 1'b0;
            copy_ff <= 1'b0;
            blk_ff <= 10'h000;
            addr_idx_ff <= 3'h0;
            after_stat_ff <= 1'b0;
            after_id_ff <= 1'b0;
            id_idx_ff <= 3'h0;
            id_ff <= '{default: 8'h00};
            last_ff <= 8'h00;
            nstat_ff <= 8'h00;
            prog_ctx_ff <= 1'b0;
            cache_ctx_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            kind_ff <= nxt_kind;
            byte_ff <= nxt_byte;
            cle_ff <= nxt_cle;
            ale_ff <= nxt_ale;
            we_n_ff <= nxt_we_n;
            re_n_ff <= nxt_re_n;
            oe_ff <= nxt_oe;
            wp_n_ff <= nxt_wp_n;
            wb_cnt_ff <= nxt_wb_cnt;
            serial_ff <= nxt_serial;
            cache_ff <= nxt_cache;
            copy_ff <= nxt_copy;
            blk_ff <= nxt_blk;
            addr_idx_ff <= nxt_addr_idx;
            after_stat_ff <= nxt_after_stat;
            after_id_ff <= nxt_after_id;
            id_idx_ff <= nxt_id_idx;
            id_ff <= nxt_id;
            last_ff <= nxt_last;
            nstat_ff <= nxt_nstat;
            prog_ctx_ff <= nxt_prog_ctx;
            cache_ctx_ff <= nxt_cache_ctx;
        end
    end
endmodule : nhc_host

// >>> nhc_host_sva.sv
// Port checker for the NAND host controller
`timescale 1ns/100ps
module nhc_host_sva (
    input wire logic aclk, aresetn, awvalid, wvalid, bvalid, bready, arvalid, rvalid, rready,
    input wire logic [1:0] bresp,
    input wire logic [31:0] rdata,
    input wire logic nand_cle, nand_ale, nand_we_n, read_strobe_n, nand_io_oe, ready_busy_out,
    input wire logic [7:0] nand_io_out
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Bus answers and holds
    a_wr_answer: assert property (awvalid && wvalid && !bvalid |=> bvalid) else $error("no bvalid");
    a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("b drop");
    a_rd_answer: assert property (arvalid && !rvalid |=> rvalid) else $error("no rvalid");
    a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("r drop");
    // Byte stays driven across the rising strobe
    a_we_pulse: assert property ($fell(nand_we_n) |=> nand_we_n && $stable(nand_io_out)
        && nand_io_oe) else $error("bad write strobe");
    a_re_pulse: assert property ($fell(read_strobe_n) |=> read_strobe_n)
        else $error("bad read strobe");
    a_we_clean: assert property (!nand_we_n |-> nand_io_oe && read_strobe_n && !(nand_cle
        && nand_ale)) else $error("write cycle clash");
    a_busy_cmd: assert property (!ready_busy_out && nand_cle && !nand_we_n
        |-> nand_io_out inside {8'h70, 8'hFF}) else $error("command while busy");
    c_busy_cmd: cover property (!ready_busy_out && $fell(nand_we_n));
    c_read: cover property ($fell(read_strobe_n));
    c_refuse: cover property (bvalid && bresp == 2'h2);
endmodule : nhc_host_sva
bind nhc_host nhc_host_sva i_nhc_host_sva (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .wvalid(wvalid), .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .rvalid(rvalid),
    .rready(rready), .bresp(bresp), .rdata(rdata), .nand_cle(nand_cle), .nand_ale(nand_ale),
    .nand_we_n(nand_we_n), .read_strobe_n(read_strobe_n), .nand_io_oe(nand_io_oe),
    .ready_busy_out(ready_busy_out), .nand_io_out(nand_io_out));

// >>> nhc_pkg.sv
// Constants, commands and register map of the NAND host controller
package nhc_pkg;
    // Clock and device timing
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned WB_TIME_NS = 100;
    localparam int unsigned WB_CYCLES = (WB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] WB_CNT = 3'(WB_CYCLES);

    // Register byte offsets on the AXI4-Lite port
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CYCLE = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam logic [7:0] ADDR_RDATA = 8'h0C;
    localparam logic [7:0] ADDR_NSTAT = 8'h10;
    localparam logic [7:0] ADDR_ID_LO = 8'h14;
    localparam logic [7:0] ADDR_ID_HI = 8'h18;

    // Control register bits
    localparam int unsigned CTRL_WP_EN = 0;
    localparam int unsigned CTRL_CE = 1;
    localparam int unsigned CTRL_ERR_CLR = 2;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    // Cycle register layout: byte in [7:0], kind in [10:8]
    localparam int unsigned CYC_KIND_LSB = 8;
    localparam int unsigned KIND_W = 3;

    // Device status byte bit positions
    localparam int unsigned SB_FAIL_CUR = 0;
    localparam int unsigned SB_FAIL_PREV = 1;
    localparam int unsigned SB_PB_READY = 5;
    localparam int unsigned SB_DC_READY = 6;

    // Row address cycles holding the block address
    localparam logic [2:0] ADDR_IDX_BLK_LO = 3'h2;
    localparam logic [2:0] ADDR_IDX_BLK_HI = 3'h3;
    localparam int unsigned BLK_LSB = 6;
    localparam logic [2:0] ID_BYTES = 3'h5;

    // Device commands
    localparam logic [7:0] CMD_READ = 8'h00;
    localparam logic [7:0] CMD_READ_GO = 8'h30;
    localparam logic [7:0] CMD_CREAD = 8'h31;
    localparam logic [7:0] CMD_CREAD_LAST = 8'h3F;
    localparam logic [7:0] CMD_COPY_READ = 8'h3A;
    localparam logic [7:0] CMD_SERIAL_IN = 8'h80;
    localparam logic [7:0] CMD_COL_CHG = 8'h85;
    localparam logic [7:0] CMD_COPY_PROG = 8'h8C;
    localparam logic [7:0] CMD_PROG = 8'h10;
    localparam logic [7:0] CMD_CACHE_PROG = 8'h15;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
    localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
    localparam logic [7:0] CMD_ID = 8'h90;
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam logic [7:0] CMD_RESET = 8'hFF;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [KIND_W-1:0] {KIND_CMD, KIND_ADDR, KIND_WDATA, KIND_RDATA,
        KIND_WAIT} nhc_kind_e;

    // Commands after which the device pulls ready/busy low
    function automatic logic nhc_busy_cmd(input logic [7:0] cmd);
        nhc_busy_cmd = (cmd == CMD_PROG) || (cmd == CMD_CACHE_PROG) || (cmd == CMD_ERASE_GO)
            || (cmd == CMD_READ_GO) || (cmd == CMD_COPY_READ) || (cmd == CMD_CREAD)
            || (cmd == CMD_CREAD_LAST) || (cmd == CMD_RESET);
    endfunction : nhc_busy_cmd
endpackage : nhc_pkg

// >>> test_nhc_host.sv
// Self-checking bench for the NAND host controller
`timescale 1ns/100ps
module test_nhc_host;
    import nhc_pkg::*;
    localparam logic [7:0] MK = 8'h5A; // Arbitrary value
    localparam logic [7:0] DV = 8'hC3; // Arbitrary value
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0, io_out, io_in;
    logic [31:0] wdata = 0, rdata, d;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bresp, rresp, r;
    logic awready, wready, bvalid, arready, rvalid, ce_n, cle, ale, we_n, re_n, wp_n, oe, rb;
    int failures = 0, samples_checked = 0;
    always #50 aclk = ~aclk;
    nhc_host i_nhc_host (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .nand_ce_n(ce_n), .nand_cle(cle), .nand_ale(ale), .nand_we_n(we_n), .read_strobe_n(re_n),
        .nand_wp_n(wp_n), .nand_io_out(io_out), .nand_io_oe(oe), .nand_io_in(io_in),
        .ready_busy_out(rb));
    nhc_dev_model #(.MAKER(MK), .DEVICE(DV)) i_nhc_dev_model (.aclk(aclk), .ce_n(ce_n),
        .cle(cle), .we_n(we_n), .re_n(re_n), .wp_n(wp_n), .io_host(io_out), .io_dev(io_in),
        .rb(rb));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
            failures++;
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge aclk); while (!awready);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        while (!bvalid) @(posedge aclk);
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge aclk);
        v = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
    // One pin cycle or wait; after a pin cycle the engine is idle again two edges after the answer
    task automatic cyc(input nhc_kind_e k, input logic [7:0] b, input logic [1:0] er);
        wr(ADDR_CYCLE, {21'h0, k, b});
        chk("cycle resp", 32'(er), 32'(r));
        repeat (2) @(posedge aclk);
    endtask : cyc
    task automatic settle();
        cyc(KIND_WAIT, 8'h00, RESP_OKAY);
        for (int i = 0; i < 100 && (i == 0 || d[0]); i++) rd(ADDR_STAT, d);
        chk("engine idle", 32'h0, 32'(d[0]));
    endtask : settle
    task automatic addr4(input logic [7:0] row);
        cyc(KIND_ADDR, 8'h00, RESP_OKAY);
        cyc(KIND_ADDR, 8'h00, RESP_OKAY);
        cyc(KIND_ADDR, row, RESP_OKAY);
        cyc(KIND_ADDR, 8'h00, RESP_OKAY);
    endtask : addr4
    task automatic status(input logic [11:0] e);
        cyc(KIND_CMD, CMD_STATUS, RESP_OKAY);
        cyc(KIND_RDATA, 8'h00, RESP_OKAY);
        rd(ADDR_NSTAT, d);
        chk("status", 32'(e), 32'(d[11:0]));
    endtask : status
    task automatic t_regs();
        rd(ADDR_CTRL, d);
        chk("ctrl reset", 32'h0, d);
        rd(8'h3C, d);
        chk("unmapped", 32'(RESP_SLVERR), 32'(r));
        wr(ADDR_STAT, 32'h0);
        chk("read only", 32'(RESP_SLVERR), 32'(r));
        wr(ADDR_CTRL, 32'h3);
    endtask : t_regs
    task automatic t_id();
        cyc(KIND_CMD, CMD_ID, RESP_OKAY);
        cyc(KIND_ADDR, 8'h00, RESP_OKAY);
        repeat (5) cyc(KIND_RDATA, 8'h00, RESP_OKAY);
        rd(ADDR_ID_LO, d);
        chk("id low", {8'h15, 8'h80, DV, MK}, d);
        rd(ADDR_ID_HI, d);
        chk("id high", 32'h72, d);
    endtask : t_id
    task automatic t_erase();
        cyc(KIND_CMD, CMD_ERASE_SETUP, RESP_OKAY);
        cyc(KIND_ADDR, 8'h40, RESP_OKAY);
        cyc(KIND_ADDR, 8'h00, RESP_OKAY);
        cyc(KIND_CMD, CMD_ERASE_GO, RESP_OKAY);
        cyc(KIND_CMD, CMD_ID, RESP_SLVERR);
        cyc(KIND_CMD, CMD_STATUS, RESP_OKAY);
        settle();
        status(12'h4E0);
        wr(ADDR_CTRL, 32'h7);
    endtask : t_erase
    task automatic t_cache();
        cyc(KIND_CMD, CMD_SERIAL_IN, RESP_OKAY);
        addr4(8'h40);
        cyc(KIND_WDATA, 8'hA5, RESP_OKAY);
        cyc(KIND_CMD, CMD_CACHE_PROG, RESP_OKAY);
        settle();
        cyc(KIND_CMD, CMD_SERIAL_IN, RESP_OKAY);
        cyc(KIND_ADDR, 8'h00, RESP_OKAY);
        cyc(KIND_ADDR, 8'h00, RESP_OKAY);
        cyc(KIND_ADDR, 8'h80, RESP_SLVERR);
        cyc(KIND_ADDR, 8'h40, RESP_OKAY);
        cyc(KIND_ADDR, 8'h00, RESP_OKAY);
        cyc(KIND_CMD, CMD_ERASE_SETUP, RESP_SLVERR);
        cyc(KIND_CMD, CMD_PROG, RESP_OKAY);
        settle();
        status(12'h4E0);
        cyc(KIND_CMD, CMD_PROG, RESP_SLVERR);
    endtask : t_cache
    task automatic t_copy();
        wr(ADDR_CTRL, 32'h2);
        cyc(KIND_CMD, CMD_READ, RESP_OKAY);
        addr4(8'h40);
        cyc(KIND_CMD, CMD_COPY_READ, RESP_OKAY);
        settle();
        cyc(KIND_RDATA, 8'h00, RESP_OKAY);
        cyc(KIND_CMD, CMD_COPY_PROG, RESP_OKAY);
        addr4(8'h40);
        chk("copy wp", 32'h1, 32'(wp_n));
        cyc(KIND_CMD, CMD_PROG, RESP_OKAY);
        settle();
    endtask : t_copy
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_id();
        t_erase();
        t_cache();
        t_copy();
        summarize();
    end
    // Whole run needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        summarize();
    end
endmodule : test_nhc_host
